/* File: src/scfc_cfg.svh */
/*
 * Offsets, field positions, status bit positions and reset values of the serial character format block.
 * Assumes inclusion by bare name from the block's single module and its bench.
 */
`ifndef SCFC_CFG_SVH
`define SCFC_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SCFC_OFF_DATA     4'h0
`define SCFC_OFF_STATUS   4'h4
`define SCFC_OFF_DIV_LO   4'h0
`define SCFC_OFF_DIV_HI   4'h4
`define SCFC_OFF_EFR      4'h8
`define SCFC_OFF_LFC      4'hC

// ****************************************
// Field positions of line_format_control
// ****************************************
`define SCFC_BIT_DLAB     7
`define SCFC_BIT_BRK      6
`define SCFC_BIT_PFORCE   5
`define SCFC_BIT_PEVEN    4
`define SCFC_BIT_PEN      3
`define SCFC_BIT_STOP     2

// ****************************************
// Status bit positions
// ****************************************
`define SCFC_ST_TXBUSY    0
`define SCFC_ST_RXVALID   1
`define SCFC_ST_PARERR    2
`define SCFC_ST_FRMERR    3

// ****************************************
// Reset values
// ****************************************
`define SCFC_LFC_RST      8'h00
`define SCFC_EFR_RST      8'h00
`define SCFC_DIV_RST      16'h0001

`endif

/* File: src/scfc_pkg.sv */
/*
 * Types of the serial character format block: phase enum, bus request and full state.
 * Assumes the configuration header is on the include path.
 */
package scfc_pkg;

	typedef enum logic [2:0]
	{
		SCFC_IDLE  = 3'b000,
		SCFC_START = 3'b001,
		SCFC_DATA  = 3'b010,
		SCFC_PAR   = 3'b011,
		SCFC_STOP  = 3'b100
	} scfc_phase_e;

	typedef struct packed
	{
		logic        read;
		logic        write;
		logic [3:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} scfc_avs_req_s;

	typedef struct packed
	{
		logic [7:0]  lfc;
		logic [15:0] div;
		logic [7:0]  efr;
		logic        ack;
		logic [31:0] rdata;
		scfc_phase_e tx_st;
		logic [7:0]  tx_sh;
		logic        tx_par;
		logic [15:0] tx_cnt;
		logic [1:0]  tx_half;
		logic [2:0]  tx_bit;
		logic        tx_line;
		scfc_phase_e rx_st;
		logic [7:0]  rx_sh;
		logic [15:0] rx_cnt;
		logic [1:0]  rx_half;
		logic [2:0]  rx_bit;
		logic [7:0]  rx_data;
		logic        rx_valid;
		logic        par_err;
		logic        frm_err;
		logic        rx_prev;
	} scfc_state_s;

endpackage

/* File: src/scfc_top.sv */
/*
 * Serial character format control with a small transmitter and receiver behind an Avalon-MM slave.
 * Assumes serial input rxd is synchronous to ref_clk and the bus master keeps Avalon rules.
 */
`include "scfc_cfg.svh"

module scfc_top
	import scfc_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          resetn,
	input  wire scfc_avs_req_s avs_req,
	output logic               avs_waitrequest,
	output logic [31:0]        avs_readdata,
	input  wire logic          rxd,
	output logic               txd
);

	// ****************************************
	// Reset release
	// ****************************************
	logic        rst_q1;
	logic        rst_q;
	scfc_state_s s_reg;
	scfc_state_s s_next;
	logic        acc;
	logic        dlab;
	logic        rd_data;
	logic        wr_data;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_q1 <= 1'b0;
			rst_q  <= 1'b0;
		end
		else
		begin
			rst_q1 <= 1'b1;
			rst_q  <= rst_q1;
		end
	end

	// Parity for a character of the selected length under the selected format.
	function automatic logic par_of(input logic [7:0] d, input logic [7:0] f);
		logic [7:0] m;
		m = d & (8'hFF >> (2'd3 - f[1:0]));
		if (f[`SCFC_BIT_PFORCE])
			par_of = ~f[`SCFC_BIT_PEVEN];
		else
			par_of = f[`SCFC_BIT_PEVEN] ? ^m : ~^m;
	endfunction

	assign dlab            = s_reg.lfc[`SCFC_BIT_DLAB];
	assign acc             = (avs_req.read | avs_req.write) & ~s_reg.ack;
	assign wr_data         = acc & avs_req.write & avs_req.byteenable[0] & ~dlab
		& (avs_req.address == `SCFC_OFF_DATA);
	assign rd_data         = acc & avs_req.read & ~dlab & (avs_req.address == `SCFC_OFF_DATA);
	assign avs_waitrequest = (avs_req.read | avs_req.write) & ~s_reg.ack;
	assign avs_readdata    = s_reg.rdata;
	assign txd             = s_reg.tx_line & ~s_reg.lfc[`SCFC_BIT_BRK];

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		s_next     = s_reg;
		s_next.ack = acc;
		// Bus side: one wait cycle, then read data from the state captured at acceptance.
		if (acc && avs_req.read)
		begin
			s_next.rdata = 32'h0000_0000;
			if (avs_req.address == `SCFC_OFF_LFC)
				s_next.rdata[7:0] = s_reg.lfc;
			else if (dlab)
			begin
				unique case (avs_req.address)
					`SCFC_OFF_DIV_LO: s_next.rdata[7:0] = s_reg.div[7:0];
					`SCFC_OFF_DIV_HI: s_next.rdata[7:0] = s_reg.div[15:8];
					`SCFC_OFF_EFR:    s_next.rdata[7:0] = s_reg.efr;
					default:          s_next.rdata = 32'h0000_0000;
				endcase
			end
			else if (avs_req.address == `SCFC_OFF_DATA)
				s_next.rdata[7:0] = s_reg.rx_data;
			else if (avs_req.address == `SCFC_OFF_STATUS)
				s_next.rdata[3:0] = {s_reg.frm_err, s_reg.par_err, s_reg.rx_valid, s_reg.tx_st != SCFC_IDLE};
		end
		if (acc && avs_req.write && avs_req.byteenable[0])
		begin
			if (avs_req.address == `SCFC_OFF_LFC)
				s_next.lfc = avs_req.writedata[7:0];
			else if (dlab && avs_req.address == `SCFC_OFF_DIV_LO)
				s_next.div[7:0] = avs_req.writedata[7:0];
			else if (dlab && avs_req.address == `SCFC_OFF_DIV_HI)
				s_next.div[15:8] = avs_req.writedata[7:0];
			else if (dlab && avs_req.address == `SCFC_OFF_EFR)
				s_next.efr = avs_req.writedata[7:0];
		end
		if (rd_data)
			s_next.rx_valid = 1'b0;

		// Transmitter: each bit is two half-bit periods of div cycles, so 1.5 stop bits is exact.
		if (s_reg.tx_st != SCFC_IDLE)
			s_next.tx_cnt = (s_reg.tx_cnt == 16'h0000) ? s_reg.div - 16'h0001 : s_reg.tx_cnt - 16'h0001;
		if (s_reg.tx_st != SCFC_IDLE && s_reg.tx_cnt == 16'h0000 && s_reg.tx_half != 2'd0)
			s_next.tx_half = s_reg.tx_half - 2'd1;
		unique case (s_reg.tx_st)
			SCFC_IDLE:
			begin
				s_next.tx_line = 1'b1;
				// A character written while busy is dropped; software polls the busy bit.
				if (wr_data)
				begin
					s_next.tx_st   = SCFC_START;
					s_next.tx_sh   = avs_req.writedata[7:0];
					s_next.tx_par  = par_of(avs_req.writedata[7:0], s_reg.lfc);
					s_next.tx_cnt  = s_reg.div - 16'h0001;
					s_next.tx_half = 2'd1;
					s_next.tx_line = 1'b0;
				end
			end
			SCFC_START, SCFC_DATA, SCFC_PAR, SCFC_STOP:
			begin
				if (s_reg.tx_cnt == 16'h0000 && s_reg.tx_half == 2'd0)
				begin
					s_next.tx_half = 2'd1;
					if (s_reg.tx_st == SCFC_START)
					begin
						s_next.tx_st   = SCFC_DATA;
						s_next.tx_bit  = 3'd4 + {1'b0, s_reg.lfc[1:0]};
						s_next.tx_line = s_reg.tx_sh[0];
						s_next.tx_sh   = s_reg.tx_sh >> 1;
					end
					else if (s_reg.tx_st == SCFC_DATA && s_reg.tx_bit != 3'd0)
					begin
						s_next.tx_bit  = s_reg.tx_bit - 3'd1;
						s_next.tx_line = s_reg.tx_sh[0];
						s_next.tx_sh   = s_reg.tx_sh >> 1;
					end
					else if (s_reg.tx_st == SCFC_DATA && s_reg.lfc[`SCFC_BIT_PEN])
					begin
						s_next.tx_st   = SCFC_PAR;
						s_next.tx_line = s_reg.tx_par;
					end
					else if (s_reg.tx_st != SCFC_STOP)
					begin
						s_next.tx_st   = SCFC_STOP;
						s_next.tx_line = 1'b1;
						if (!s_reg.lfc[`SCFC_BIT_STOP])
							s_next.tx_half = 2'd1;
						else
							s_next.tx_half = (s_reg.lfc[1:0] == 2'b00) ? 2'd2 : 2'd3;
					end
					else
						s_next.tx_st = SCFC_IDLE;
				end
			end
			default:
				s_next.tx_st = SCFC_IDLE;
		endcase

		// Receiver: start is checked half a bit in, then every bit is sampled at its middle.
		s_next.rx_prev = rxd;
		if (s_reg.rx_st != SCFC_IDLE)
			s_next.rx_cnt = (s_reg.rx_cnt == 16'h0000) ? s_reg.div - 16'h0001 : s_reg.rx_cnt - 16'h0001;
		if (s_reg.rx_st != SCFC_IDLE && s_reg.rx_cnt == 16'h0000 && s_reg.rx_half != 2'd0)
			s_next.rx_half = s_reg.rx_half - 2'd1;
		unique case (s_reg.rx_st)
			SCFC_IDLE:
			begin
				if (s_reg.rx_prev && !rxd)
				begin
					s_next.rx_st   = SCFC_START;
					s_next.rx_cnt  = s_reg.div - 16'h0001;
					s_next.rx_half = 2'd0;
				end
			end
			SCFC_START, SCFC_DATA, SCFC_PAR, SCFC_STOP:
			begin
				if (s_reg.rx_cnt == 16'h0000 && s_reg.rx_half == 2'd0)
				begin
					s_next.rx_half = 2'd1;
					if (s_reg.rx_st == SCFC_START)
					begin
						// A start that has gone high again by mid-bit was a glitch.
						s_next.rx_st  = rxd ? SCFC_IDLE : SCFC_DATA;
						s_next.rx_bit = 3'd4 + {1'b0, s_reg.lfc[1:0]};
					end
					else if (s_reg.rx_st == SCFC_DATA)
					begin
						s_next.rx_sh  = {rxd, s_reg.rx_sh[7:1]};
						s_next.rx_bit = s_reg.rx_bit - 3'd1;
						if (s_reg.rx_bit == 3'd0)
							s_next.rx_st = s_reg.lfc[`SCFC_BIT_PEN] ? SCFC_PAR : SCFC_STOP;
					end
					else if (s_reg.rx_st == SCFC_PAR)
					begin
						s_next.rx_st   = SCFC_STOP;
						s_next.par_err = rxd != par_of(s_reg.rx_sh >> (2'd3 - s_reg.lfc[1:0]), s_reg.lfc);
					end
					else
					begin
						// Only the first stop bit is checked; a new start may follow at once.
						s_next.rx_st    = SCFC_IDLE;
						s_next.frm_err  = ~rxd;
						s_next.rx_data  = s_reg.rx_sh >> (2'd3 - s_reg.lfc[1:0]);
						s_next.rx_valid = 1'b1;
						if (!s_reg.lfc[`SCFC_BIT_PEN])
							s_next.par_err = 1'b0;
					end
				end
			end
			default:
				s_next.rx_st = SCFC_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_q)
	begin
		if (!rst_q)
		begin
			s_reg         <= '0;
			s_reg.lfc     <= `SCFC_LFC_RST;
			s_reg.efr     <= `SCFC_EFR_RST;
			s_reg.div     <= `SCFC_DIV_RST;
			s_reg.tx_line <= 1'b1;
			s_reg.rx_prev <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_q);

	a_break_line_low: assert property (s_reg.lfc[`SCFC_BIT_BRK] |-> !txd) else $error("break not low");
	a_reset_format_zero: assert property ($rose(rst_q) |-> s_reg.lfc == 8'h00) else $error("format not zero");
	a_divisor_hidden: assert property (
		acc && avs_req.write && !dlab && avs_req.address == `SCFC_OFF_DIV_HI |=> $stable(s_reg.div))
		else $error("divisor written while hidden");
	a_general_denied: assert property (
		acc && avs_req.write && dlab && avs_req.address == `SCFC_OFF_DATA && s_reg.tx_st == SCFC_IDLE
		|=> s_reg.tx_st == SCFC_IDLE) else $error("data taken in divisor mode");
	a_start_level: assert property (s_reg.tx_st == SCFC_START |-> !s_reg.tx_line) else $error("start not low");
	a_stop_level: assert property (s_reg.tx_st == SCFC_STOP |-> s_reg.tx_line) else $error("stop not high");
	a_parity_value: assert property (
		wr_data && s_reg.tx_st == SCFC_IDLE
		|=> s_reg.tx_par == (s_reg.lfc[`SCFC_BIT_PFORCE] ? ~s_reg.lfc[`SCFC_BIT_PEVEN]
		: (s_reg.lfc[`SCFC_BIT_PEVEN] ^ ~^($past(avs_req.writedata[7:0]) & (8'hFF >> (2'd3 - s_reg.lfc[1:0]))))))
		else $error("parity wrong");
	a_no_parity_skip: assert property (
		$past(s_reg.tx_st) == SCFC_DATA && s_reg.tx_st != SCFC_DATA
		|-> s_reg.tx_st == (s_reg.lfc[`SCFC_BIT_PEN] ? SCFC_PAR : SCFC_STOP)) else $error("parity phase wrong");
	a_stop_length: assert property (
		$rose(s_reg.tx_st == SCFC_STOP) |-> s_reg.tx_half == (!s_reg.lfc[`SCFC_BIT_STOP] ? 2'd1
		: (s_reg.lfc[1:0] == 2'b00 ? 2'd2 : 2'd3))) else $error("stop length wrong");
	a_word_length: assert property (
		$rose(s_reg.tx_st == SCFC_DATA) |-> s_reg.tx_bit == 3'd4 + {1'b0, s_reg.lfc[1:0]}) else $error("word length wrong");

endmodule

/* File: bench/scfc_remote.sv */
/*
 * Remote serial port model: sends frames on rxd and samples frames from txd.
 * Assumes the bench programs the divisor to HALF, so one bit lasts 2*HALF ref_clk cycles.
 */
module scfc_remote #(parameter int HALF = 8)
(
	input  wire logic ref_clk,
	input  wire logic txd,
	output logic      rxd
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Frame tasks
	// ****************************************
	// The line idles at mark level, as an asynchronous link does between characters.
	initial rxd = 1'h1;

	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++)
		begin
			rxd <= bits[i];
			repeat (2 * HALF) @(posedge ref_clk);
		end
		rxd <= 1'h1;
	endtask

	// Sampling in mid-bit keeps the result blind to edge jitter of a few cycles.
	task automatic grab(input int n, output logic [11:0] bits);
		int w;
		bits = 12'hFFF;
		w = 0;
		while (txd !== 1'h0 && w < 400)
		begin
			@(posedge ref_clk);
			w++;
		end
		repeat (HALF) @(posedge ref_clk);
		for (int i = 0; i < n; i++)
		begin
			if (i > 0)
				repeat (2 * HALF) @(posedge ref_clk);
			bits[i] = txd;
		end
	endtask
endmodule

/* File: bench/scfc_top_tb.sv */
/*
 * Self-checking bench of the serial character format block.
 * Assumes every bus request is answered by the design and the remote model sits on txd and rxd.
 */
`include "scfc_cfg.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (e)); end end

module scfc_top_tb
	import scfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Clock, reset, instances and helpers
	// ****************************************
	localparam int HALF  = 8;
	localparam int LIMIT = 20000;
	logic          ref_clk = 1'h0;
	logic          resetn = 1'h0;
	scfc_avs_req_s req = '0;
	logic          waitreq;
	logic [31:0]   rdata;
	logic          rxd;
	logic          txd;
	logic [31:0]   q;
	logic [11:0]   bits;
	int            err_count = 0;
	int            check_count = 0;
	int            cyc = 0;

	scfc_top i_scfc_top (.ref_clk(ref_clk), .resetn(resetn), .avs_req(req), .avs_waitrequest(waitreq),
		.avs_readdata(rdata), .rxd(rxd), .txd(txd));
	scfc_remote #(.HALF(HALF)) i_scfc_remote (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));

	always #2.5 ref_clk = ~ref_clk;

	task automatic tally_and_finish();
		if (err_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			err_count++;
			tally_and_finish();
		end
	end

	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] r);
		@(posedge ref_clk);
		req.read <= ~wr;
		req.write <= wr;
		req.address <= a;
		req.writedata <= {24'h000000, d};
		req.byteenable <= 4'hF;
		do
		begin
			@(posedge ref_clk);
		end
		while (waitreq !== 1'h0);
		r = rdata;
		req.read <= 1'h0;
		req.write <= 1'h0;
	endtask

	// Start, data low bit first, parity when enabled, one stop; n returns the bit count.
	function automatic logic [11:0] frame(input logic [7:0] l, input logic [7:0] d, output int n);
		logic [7:0] m;
		m = d & (8'hFF >> (3 - l[1:0]));
		n = 5 + l[1:0];
		frame = 12'hFFE;
		for (int i = 0; i < n; i++)
			frame[i + 1] = m[i];
		if (l[3])
			frame[n + 1] = l[5] ? ~l[4] : (l[4] ? ^m : ~^m);
		n = n + 2 + l[3];
	endfunction

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_dlab();
		bus(1'h0, `SCFC_OFF_LFC, 8'h00, q);
		`CHK(q, 32'h00000000);
		// With the latch hidden these land on status and the spare word, so both must be lost.
		bus(1'h1, `SCFC_OFF_DIV_HI, 8'h77, q);
		bus(1'h1, `SCFC_OFF_EFR, 8'h33, q);
		bus(1'h1, `SCFC_OFF_LFC, 8'h80, q);
		bus(1'h0, `SCFC_OFF_DIV_HI, 8'h00, q);
		`CHK(q, 32'(`SCFC_DIV_RST >> 8));
		bus(1'h0, `SCFC_OFF_EFR, 8'h00, q);
		`CHK(q, 32'(`SCFC_EFR_RST));
		bus(1'h1, `SCFC_OFF_DIV_HI, 8'h00, q);
		bus(1'h1, `SCFC_OFF_DIV_LO, 8'(HALF), q);
		repeat (4)
		begin
			@(posedge ref_clk);
			`CHK(txd, 1'h1);
		end
		bus(1'h1, `SCFC_OFF_EFR, 8'h5A, q);
		bus(1'h0, `SCFC_OFF_DIV_LO, 8'h00, q);
		`CHK(q, 32'(HALF));
		bus(1'h0, `SCFC_OFF_EFR, 8'h00, q);
		`CHK(q, 32'h0000005A);
		bus(1'h1, `SCFC_OFF_LFC, 8'h03, q);
		bus(1'h0, `SCFC_OFF_EFR, 8'h00, q);
		`CHK(q, 32'h00000000);
		bus(1'h0, `SCFC_OFF_STATUS, 8'h00, q);
		`CHK(q, 32'h00000000);
	endtask

	task automatic t_tx();
		logic [7:0]  lst [7] = '{8'h00, 8'h05, 8'h0A, 8'h1B, 8'h2A, 8'h3F, 8'h0C};
		logic [11:0] e;
		int          n, t, k, w;
		foreach (lst[i])
		begin
			bus(1'h1, `SCFC_OFF_LFC, lst[i], q);
			bus(1'h1, `SCFC_OFF_DATA, 8'hB3, q);
			e = frame(lst[i], 8'hB3, n);
			i_scfc_remote.grab(n, bits);
			`CHK(bits, e);
			t = cyc;
			k = 0;
			w = HALF * (lst[i][2] ? (lst[i][1:0] == 2'h0 ? 2 : 3) : 1);
			do
			begin
				bus(1'h0, `SCFC_OFF_STATUS, 8'h00, q);
				k++;
			end
			while (q[0] !== 1'h0 && k < 30);
			`CHK(cyc - t >= w - 3 && cyc - t <= w + 5, 1'h1);
		end
	endtask

	task automatic t_rx();
		logic [7:0]  lst [5] = '{8'h1B, 8'h1B, 8'h2A, 8'h0D, 8'h00};
		logic [4:0]  bad = 5'h0E;
		logic [11:0] f;
		logic [7:0]  d;
		int          n;
		foreach (lst[i])
		begin
			d = 8'hA5 - 8'(i);
			bus(1'h1, `SCFC_OFF_LFC, lst[i], q);
			f = frame(lst[i], d, n);
			f[n - 2] = f[n - 2] ^ bad[i];
			i_scfc_remote.send(f, n);
			bus(1'h0, `SCFC_OFF_STATUS, 8'h00, q);
			`CHK(q[3:0], {1'h0, bad[i], 1'h1, 1'h0});
			bus(1'h0, `SCFC_OFF_DATA, 8'h00, q);
			`CHK(q, {24'h000000, d & (8'hFF >> (3 - lst[i][1:0]))});
		end
	endtask

	// The character sent under break must never show on the line.
	task automatic t_break();
		bus(1'h1, `SCFC_OFF_LFC, 8'h43, q);
		bus(1'h1, `SCFC_OFF_DATA, 8'hFF, q);
		repeat (40)
		begin
			@(posedge ref_clk);
			`CHK(txd, 1'h0);
		end
		repeat (200) @(posedge ref_clk);
		`CHK(txd, 1'h0);
		bus(1'h1, `SCFC_OFF_LFC, 8'h03, q);
		@(posedge ref_clk);
		`CHK(txd, 1'h1);
	endtask

	// A reset in mid-run must drop break and format and bring the divisor back to its reset value.
	task automatic t_reset();
		bus(1'h1, `SCFC_OFF_LFC, 8'hDB, q);
		bus(1'h1, `SCFC_OFF_DIV_LO, 8'h11, q);
		resetn <= 1'h0;
		repeat (2) @(posedge ref_clk);
		`CHK(txd, 1'h1);
		resetn <= 1'h1;
		repeat (4) @(posedge ref_clk);
		bus(1'h0, `SCFC_OFF_LFC, 8'h00, q);
		`CHK(q, 32'h00000000);
		bus(1'h1, `SCFC_OFF_LFC, 8'h80, q);
		bus(1'h0, `SCFC_OFF_DIV_LO, 8'h00, q);
		`CHK(q, 32'(`SCFC_DIV_RST & 16'h00FF));
	endtask

	initial
	begin
		repeat (2) @(posedge ref_clk);
		resetn <= 1'h1;
		repeat (4) @(posedge ref_clk);
		t_dlab();
		t_tx();
		t_rx();
		t_break();
		t_reset();
		tally_and_finish();
	end
endmodule
